// File: hdl/sdsf_top.sv
/*
 * Status and fault readback bank of a compact servo drive, with step and
 * direction position counting and the power enable gate.
 * Assumes all inputs synchronous to ref_clk and an AXI4-Lite master that
 * keeps one read and one write outstanding at most.
 */
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module sdsf_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// axi4-lite write address and data
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// isolated inputs, high means current flows in the diode
	input wire logic enable_conducting,
	input wire logic general_two_conducting,
	input wire logic general_three_conducting,
	input wire logic direction_conducting,
	input wire logic fast_step_conducting,
	// emulated encoder comparators, high when plus line is higher
	input wire logic emu_a_plus_higher,
	input wire logic emu_b_plus_higher,
	// quadrature inputs are decoded elsewhere; these are counted steps
	input wire logic quad_count_pulse,
	input wire logic quad_count_up,
	// hall, switch and feedback samples
	input wire logic hall_u,
	input wire logic hall_v,
	input wire logic hall_w,
	input wire logic [3:0] dip_switch_raw,
	input wire logic [23:0] single_turn_position,
	input wire logic [11:0] multiturn_position,
	input wire logic [2:0] feedback_device_fault_code,
	input wire logic abs_encoder_present,
	input wire logic [15:0] abs_encoder_turn_capacity,
	input wire logic [31:0] abs_encoder_periods_per_rev,
	// fault sources, current and rate measures
	input wire logic [15:0] extended_fault_sources,
	input wire logic [4:0] primary_fault_source,
	input wire logic foldback_active,
	input wire logic [9:0] current_fraction,
	input wire logic [15:0] commutation_mhz,
	// outputs
	output logic fault_pin_conducting,
	output logic run_pin_conducting,
	output logic power_stage_on,
	output logic half_switching_rate_flag
);
	sdsf_pkg::sdsf_state_t r;
	sdsf_pkg::sdsf_state_t next_r;

	logic [31:0] inputs_word;
	logic [31:0] drive_word;
	logic [31:0] read_word;
	logic [31:0] wmask;
	logic step_edge;
	logic fb_fault;

	// input status word: opto levels inverted so conducting reads 0
	always_comb begin
		inputs_word = '0;
		inputs_word[sdsf_pkg::IN_ENABLE] = ~enable_conducting;
		inputs_word[sdsf_pkg::IN_GEN2] = ~general_two_conducting;
		inputs_word[sdsf_pkg::IN_GEN3] = ~general_three_conducting;
		inputs_word[sdsf_pkg::IN_DIR] = ~direction_conducting;
		inputs_word[sdsf_pkg::IN_FAST] = ~fast_step_conducting;
		inputs_word[sdsf_pkg::IN_EMU_A] = emu_a_plus_higher;
		inputs_word[sdsf_pkg::IN_EMU_B] = emu_b_plus_higher;
		inputs_word[sdsf_pkg::IN_HALL_LSB +: 3] = {hall_w, hall_v, hall_u};
		inputs_word[sdsf_pkg::IN_DIP_LSB +: 4] = dip_switch_raw;
	end

	// only codes 001 and 011 are real feedback device faults
	assign fb_fault = (feedback_device_fault_code == sdsf_pkg::FB_SENSOR_ERR) ||
		(feedback_device_fault_code == sdsf_pkg::FB_MULTITURN_ERR);

	always_comb begin
		drive_word = '0;
		drive_word[sdsf_pkg::DRV_NO_FAULT] = r.no_fault;
		drive_word[sdsf_pkg::DRV_ENABLED] = r.enabled;
		drive_word[sdsf_pkg::DRV_FOLDBACK] = foldback_active;
		drive_word[sdsf_pkg::DRV_HALF_RATE] = r.half_rate;
		drive_word[sdsf_pkg::DRV_FB_FAULT_LSB +: 3] =
			fb_fault ? feedback_device_fault_code : 3'h0;
	end

	// step counted when the diode stops conducting
	assign step_edge = r.fast_prev & ~fast_step_conducting;

	// read decode
	always_comb begin
		if (s_axi_araddr == sdsf_pkg::REG_INPUTS) begin
			read_word = inputs_word;
		end else if (s_axi_araddr == sdsf_pkg::REG_DRIVE) begin
			read_word = drive_word;
		end else if (s_axi_araddr == sdsf_pkg::REG_CONTROL) begin
			read_word = r.control;
		end else if (s_axi_araddr == sdsf_pkg::REG_EXT_FAULT) begin
			read_word = {16'h0000, r.ext_fault};
		end else if (s_axi_araddr == sdsf_pkg::REG_FAULT_NUM) begin
			read_word = {27'h0, r.fault_num};
		end else if (s_axi_araddr == sdsf_pkg::REG_POSITION) begin
			read_word = {8'h00, single_turn_position};
		end else if (s_axi_araddr == sdsf_pkg::REG_MULTITURN) begin
			read_word = {{20{multiturn_position[11]}}, multiturn_position};
		end else if (s_axi_araddr == sdsf_pkg::REG_POS_CMD) begin
			read_word = r.pos_cmd;
		end else if (s_axi_araddr == sdsf_pkg::REG_ABS_TURNS) begin
			read_word = abs_encoder_present ? {16'h0000, abs_encoder_turn_capacity} : '0;
		end else if (s_axi_araddr == sdsf_pkg::REG_ABS_PERIODS) begin
			read_word = abs_encoder_present ? abs_encoder_periods_per_rev : '0;
		end else if (s_axi_araddr == sdsf_pkg::REG_IDENT) begin
			read_word = {23'h0, sdsf_pkg::BASE_UNIT_ID, sdsf_pkg::LOGIC_REVISION};
		end else if (s_axi_araddr == sdsf_pkg::REG_GEAR) begin
			read_word = {16'h0000, r.gear};
		end else begin
			read_word = '0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_strb
			assign wmask[gi*8 +: 8] = {8{r.wstrb[gi]}};
		end
	endgenerate

	always_comb begin
		next_r = r;
		// write channel: take address and data in either order
		next_r.awready = 1'b0;
		next_r.wready = 1'b0;
		next_r.control[sdsf_pkg::CTL_FAULT_CLR] = 1'b0;
		if (r.wstate == sdsf_pkg::SDSF_IDLE) begin
			if (s_axi_awvalid && !r.aw_got && !r.awready) begin
				next_r.awready = 1'b1;
				next_r.awaddr = s_axi_awaddr;
			end
			if (r.awready) begin
				next_r.aw_got = 1'b1;
			end
			if (s_axi_wvalid && !r.w_got && !r.wready) begin
				next_r.wready = 1'b1;
				next_r.wdata = s_axi_wdata;
				next_r.wstrb = s_axi_wstrb;
			end
			if (r.wready) begin
				next_r.w_got = 1'b1;
			end
			if (r.aw_got && r.w_got) begin
				next_r.wstate = sdsf_pkg::SDSF_RESP;
				next_r.bresp = 2'b00;
				if (r.awaddr == sdsf_pkg::REG_CONTROL) begin
					// sw enable, source, clear and mode are writable
					next_r.control = (r.control & ~wmask) | (r.wdata & wmask);
				end else if (r.awaddr == sdsf_pkg::REG_GEAR) begin
					next_r.gear = (r.gear & ~wmask[15:0]) | (r.wdata[15:0] & wmask[15:0]);
				end else if (r.awaddr == sdsf_pkg::REG_POS_CMD) begin
					next_r.pos_cmd = (r.pos_cmd & ~wmask) | (r.wdata & wmask);
				end else if (r.awaddr > sdsf_pkg::REG_GEAR) begin
					next_r.bresp = 2'b10;
				end
			end
		end else if (s_axi_bready) begin
			next_r.wstate = sdsf_pkg::SDSF_IDLE;
			next_r.aw_got = 1'b0;
			next_r.w_got = 1'b0;
		end

		// read channel
		next_r.arready = 1'b0;
		if (r.rstate == sdsf_pkg::SDSF_IDLE) begin
			if (s_axi_arvalid) begin
				next_r.arready = 1'b1;
				next_r.rdata = read_word;
				next_r.rresp = (s_axi_araddr > sdsf_pkg::REG_GEAR) ? 2'b10 : 2'b00;
				next_r.rstate = sdsf_pkg::SDSF_RESP;
			end
		end else if (s_axi_rready) begin
			next_r.rstate = sdsf_pkg::SDSF_IDLE;
		end

		// extended fault log: fresh faults replace, zero keeps last
		if (extended_fault_sources != 16'h0000) begin
			next_r.ext_fault = extended_fault_sources;
		end

		// primary fault latched; a clear lets the present cause through
		if (r.control[sdsf_pkg::CTL_FAULT_CLR]) begin
			next_r.fault_num = primary_fault_source;
		end else if (r.fault_num == 5'h00) begin
			next_r.fault_num = primary_fault_source;
		end
		next_r.no_fault = (next_r.fault_num == 5'h00);

		// power only with hardware and software enable and no fault
		next_r.enabled = enable_conducting & r.control[sdsf_pkg::CTL_SW_ENABLE]
			& r.no_fault;
		next_r.run_out = next_r.enabled;
		next_r.fault_out = next_r.no_fault;

		// rate hysteresis keeps the switching rate from chattering
		if (!r.half_rate) begin
			if (current_fraction > sdsf_pkg::CUR_HIGH &&
				commutation_mhz < sdsf_pkg::FREQ_LOW_MHZ) begin
				next_r.half_rate = 1'b1;
			end
		end else if (current_fraction < sdsf_pkg::CUR_LOW ||
			commutation_mhz > sdsf_pkg::FREQ_HIGH_MHZ) begin
			next_r.half_rate = 1'b0;
		end

		// position command accumulation
		next_r.fast_prev = fast_step_conducting;
		if (r.control[sdsf_pkg::CTL_MODE_LSB +: 3] == sdsf_pkg::MODE_POSITION &&
			r.gear != 16'h0000) begin
			if (r.control[sdsf_pkg::CTL_POS_SRC]) begin
				if (step_edge) begin
					// inactive direction with positive gear counts up
					if (direction_conducting ^ r.gear[15]) begin
						next_r.pos_cmd = r.pos_cmd - 32'h0000_0001;
					end else begin
						next_r.pos_cmd = r.pos_cmd + 32'h0000_0001;
					end
				end
			end else if (quad_count_pulse) begin
				if (quad_count_up ^ r.gear[15]) begin
					next_r.pos_cmd = r.pos_cmd + 32'h0000_0001;
				end else begin
					next_r.pos_cmd = r.pos_cmd - 32'h0000_0001;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
			r.control <= sdsf_pkg::CTL_RESET;
			r.gear <= sdsf_pkg::GEAR_RESET;
			r.no_fault <= 1'b1;
			r.fault_out <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	// state bit 0 is set only in the response state, so valid comes straight from a flop
	assign s_axi_bvalid = r.wstate[0];
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid = r.rstate[0];
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign fault_pin_conducting = r.fault_out;
	assign run_pin_conducting = r.run_out;
	assign power_stage_on = r.enabled;
	assign half_switching_rate_flag = r.half_rate;
endmodule

// File: hdl/sdsf_pkg.sv
/*
 * Package for the servo drive status and fault readback block: register
 * offsets, field layouts, reset values, fault encodings and switching-rate
 * thresholds.
 * Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
 */
package sdsf_pkg;
	// register byte offsets
	localparam logic [7:0] REG_INPUTS = 8'h00;
	localparam logic [7:0] REG_DRIVE = 8'h04;
	localparam logic [7:0] REG_CONTROL = 8'h08;
	localparam logic [7:0] REG_EXT_FAULT = 8'h0C;
	localparam logic [7:0] REG_FAULT_NUM = 8'h10;
	localparam logic [7:0] REG_POSITION = 8'h14;
	localparam logic [7:0] REG_MULTITURN = 8'h18;
	localparam logic [7:0] REG_POS_CMD = 8'h1C;
	localparam logic [7:0] REG_ABS_TURNS = 8'h20;
	localparam logic [7:0] REG_ABS_PERIODS = 8'h24;
	localparam logic [7:0] REG_IDENT = 8'h28;
	localparam logic [7:0] REG_GEAR = 8'h2C;

	// control register fields
	localparam int CTL_SW_ENABLE = 0;
	localparam int CTL_POS_SRC = 1;
	localparam int CTL_FAULT_CLR = 2;
	localparam int CTL_MODE_LSB = 4;
	localparam logic [31:0] CTL_RESET = 32'h0000_0033;

	// inputs register fields
	localparam int IN_ENABLE = 0;
	localparam int IN_GEN2 = 1;
	localparam int IN_GEN3 = 2;
	localparam int IN_DIR = 3;
	localparam int IN_FAST = 4;
	localparam int IN_EMU_A = 5;
	localparam int IN_EMU_B = 6;
	localparam int IN_HALL_LSB = 8;
	localparam int IN_DIP_LSB = 12;

	// drive status fields
	localparam int DRV_NO_FAULT = 0;
	localparam int DRV_ENABLED = 1;
	localparam int DRV_FOLDBACK = 2;
	localparam int DRV_HALF_RATE = 3;
	localparam int DRV_FB_FAULT_LSB = 4;

	localparam logic [2:0] MODE_POSITION = 3'h3;
	localparam logic [2:0] FB_SENSOR_ERR = 3'h1;
	localparam logic [2:0] FB_MULTITURN_ERR = 3'h3;
	localparam logic [15:0] GEAR_RESET = 16'h0100;

	// identity values are arbitrary
	localparam logic [3:0] LOGIC_REVISION = 4'h1;
	localparam logic [4:0] BASE_UNIT_ID = 5'h05;

	// fractions of peak current in 1/1024 and commutation rate in mHz
	localparam logic [9:0] CUR_HIGH = 10'h21F;
	localparam logic [9:0] CUR_LOW = 10'h148;
	localparam logic [15:0] FREQ_LOW_MHZ = 16'h0B54;
	localparam logic [15:0] FREQ_HIGH_MHZ = 16'h12A2;

	typedef enum logic [1:0] {
		SDSF_IDLE = 2'b00,
		SDSF_RESP = 2'b01
	} sdsf_bus_t;

	typedef struct packed {
		logic [31:0] pos_cmd;
		logic [31:0] control;
		logic [15:0] gear;
		logic [15:0] ext_fault;
		logic [4:0] fault_num;
		logic no_fault;
		logic enabled;
		logic half_rate;
		logic fast_prev;
		logic fault_out;
		logic run_out;
		sdsf_bus_t wstate;
		sdsf_bus_t rstate;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] bresp;
		logic awready;
		logic wready;
		logic arready;
	} sdsf_state_t;
endpackage

// File: tb/sdsf_props.sv
/*
 * Concurrent checks on the readback bank ports.
 * Assumes the bench holds inputs steady while a read is under way.
 */
`timescale 1ns/1ps
module sdsf_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// read channel
	input wire logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	// sampled levels
	input wire logic enable_conducting,
	input wire logic emu_a_plus_higher,
	input wire logic hall_u,
	input wire logic hall_v,
	input wire logic hall_w,
	input wire logic [3:0] dip_switch_raw,
	input wire logic [2:0] feedback_device_fault_code,
	input wire logic [23:0] single_turn_position,
	input wire logic [11:0] multiturn_position,
	input wire logic [9:0] current_fraction,
	input wire logic [15:0] commutation_mhz,
	// outputs
	input wire logic run_pin_conducting,
	input wire logic power_stage_on,
	input wire logic half_switching_rate_flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// first cycle of read data; address is still held then
	wire rd_new = s_axi_rvalid && s_axi_arready;
	wire rd_in = rd_new && s_axi_araddr == sdsf_pkg::REG_INPUTS;
	logic [2:0] fb;
	assign fb = feedback_device_fault_code;
	a_run_pin_match: assert property (run_pin_conducting == power_stage_on)
		else $error("run pin differs from power stage");
	a_power_needs_enable: assert property (power_stage_on |-> $past(enable_conducting))
		else $error("power on without enable input");
	a_enable_opto_level: assert property (rd_in |-> s_axi_rdata[0] == !$past(enable_conducting))
		else $error("enable input level wrong");
	a_emu_chan_level: assert property (rd_in |-> s_axi_rdata[5] == $past(emu_a_plus_higher))
		else $error("channel a level wrong");
	a_hall_state_value: assert property (rd_in |->
		s_axi_rdata[10:8] == {$past(hall_w), $past(hall_v), $past(hall_u)})
		else $error("hall value wrong");
	a_dip_switch_value: assert property (rd_in |-> s_axi_rdata[15:12] == $past(dip_switch_raw))
		else $error("dip switch value wrong");
	a_fb_fault_code: assert property (rd_new && s_axi_araddr == sdsf_pkg::REG_DRIVE |->
		s_axi_rdata[6:4] == (($past(fb) == 3'h1 || $past(fb) == 3'h3) ? $past(fb) : 3'h0))
		else $error("feedback fault code wrong");
	a_single_turn_pos: assert property (rd_new && s_axi_araddr == sdsf_pkg::REG_POSITION |->
		s_axi_rdata == {8'h00, $past(single_turn_position)})
		else $error("position word wrong");
	a_multiturn_sign: assert property (rd_new && s_axi_araddr == sdsf_pkg::REG_MULTITURN |->
		s_axi_rdata == {{20{$past(multiturn_position[11])}}, $past(multiturn_position)})
		else $error("multiturn word wrong");
	a_rate_half_set: assert property ($rose(half_switching_rate_flag) |->
		$past(current_fraction) > 10'h21F && $past(commutation_mhz) < 16'h0B54)
		else $error("half rate entered without cause");
	a_rate_half_clear: assert property ($fell(half_switching_rate_flag) |->
		$past(current_fraction) < 10'h148 || $past(commutation_mhz) > 16'h12A2)
		else $error("half rate left without cause");
	a_rate_half_enter: assert property (!half_switching_rate_flag && current_fraction > 10'h21F
		&& commutation_mhz < 16'h0B54 |-> ##[1:2] half_switching_rate_flag)
		else $error("half rate not entered");
endmodule
bind sdsf_top sdsf_props sdsf_props_inst (.*);

// File: tb/sdsf_host.sv
/*
 * Host model: an AXI4-Lite master offering one read or write at a time.
 * Assumes its tasks are called from one process of the bench.
 */
`timescale 1ns/1ps
module sdsf_host (
	// clock
	input wire logic ref_clk,
	// write side
	output logic s_axi_awvalid,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_wvalid,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_bready,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	// read side
	output logic s_axi_arvalid,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_rready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
	initial {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = 52'h0;
	// released addresses and write data are inverted so stale values are never mistaken for live ones; the write strobe stays at 4'hF
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
		fork
			begin do @(posedge ref_clk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; s_axi_awaddr <= ~a; end
			begin do @(posedge ref_clk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; s_axi_wdata <= ~d; end
		join
		while (!s_axi_bvalid) @(posedge ref_clk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		{s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) begin s_axi_arvalid <= 1'b0; s_axi_araddr <= ~a; end
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
endmodule

// File: tb/testbench.sv
/*
 * Self-checking bench for the readback bank: reads are noted in a queue
 * and compared when the read data handshake happens.
 * Assumes the host model and the bound checker beside the design.
 */
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 1'b0, rst_b = 1'b0;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb, dip_switch_raw;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic enable_conducting, general_two_conducting, general_three_conducting;
	logic direction_conducting, fast_step_conducting, emu_a_plus_higher, emu_b_plus_higher;
	logic quad_count_pulse, quad_count_up, hall_u, hall_v, hall_w, abs_encoder_present;
	logic foldback_active, fault_pin_conducting, run_pin_conducting, power_stage_on;
	logic half_switching_rate_flag;
	logic [23:0] single_turn_position;
	logic [11:0] multiturn_position;
	logic [2:0] feedback_device_fault_code;
	logic [15:0] abs_encoder_turn_capacity, extended_fault_sources, commutation_mhz;
	logic [31:0] abs_encoder_periods_per_rev;
	logic [4:0] primary_fault_source;
	logic [9:0] current_fraction;
	logic [65:0] n;
	logic [65:0] exp_q[$];
	logic [1:0] b;
	logic [1:0] bresp_q[$];
	int miscompares = 0, checks_done = 0;
	always #5 ref_clk = ~ref_clk;
	sdsf_top sdsf_top_inst (.*);
	sdsf_host sdsf_host_inst (.*);
	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			miscompares++;
			$display("FAIL %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
		input logic [1:0] r = 2'b00);
		exp_q.push_back({r, m, e & m});
		sdsf_host_inst.rd(a);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
		bresp_q.push_back(r);
		sdsf_host_inst.wr(a, d);
	endtask
	task automatic complete_run();
		$display("checks_done %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			n = exp_q.pop_front();
			chk(s_axi_rdata & n[63:32], n[31:0]);
			chk({30'h0, s_axi_rresp}, {30'h0, n[65:64]});
		end
		if (s_axi_bvalid && s_axi_bready) begin
			b = bresp_q.pop_front();
			chk({30'h0, s_axi_bresp}, {30'h0, b});
		end
	end
	initial begin #300000; miscompares++; complete_run(); end
	initial begin
		{enable_conducting, general_two_conducting, general_three_conducting} = 3'h0;
		{direction_conducting, fast_step_conducting, emu_a_plus_higher, emu_b_plus_higher} = 4'h0;
		{quad_count_pulse, quad_count_up, hall_u, hall_v, hall_w, abs_encoder_present} = 6'h0;
		{dip_switch_raw, single_turn_position, multiturn_position} = 40'h0;
		{feedback_device_fault_code, abs_encoder_turn_capacity, abs_encoder_periods_per_rev} = 51'h0;
		{extended_fault_sources, primary_fault_source, foldback_active} = 22'h0;
		{current_fraction, commutation_mhz} = {10'h000, 16'h0FFF};
		v = $urandom(32'h26E03B38);
		tick(10);
		rst_b <= 1'b1;
		rd(sdsf_pkg::REG_CONTROL, sdsf_pkg::CTL_RESET);
		rd(sdsf_pkg::REG_GEAR, 32'h0000_0100);
		rd(8'h30, 32'h0, 32'hFFFFFFFF, 2'b10);
		repeat (8) begin
			v = $urandom;
			@(posedge ref_clk);
			{dip_switch_raw, hall_w, hall_v, hall_u, emu_b_plus_higher, emu_a_plus_higher,
				fast_step_conducting, direction_conducting, general_three_conducting,
				general_two_conducting, enable_conducting} <= v[13:0];
			rd(sdsf_pkg::REG_INPUTS, {16'h0, v[13:10], 1'b0, v[9:7], 1'b0, v[6:5], ~v[4:0]},
				32'h0000_F77F);
		end
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			feedback_device_fault_code <= 3'(i);
			foldback_active <= i[0];
			rd(sdsf_pkg::REG_DRIVE, {25'h0, (i == 1 || i == 3) ? 3'(i) : 3'h0, 1'b0, i[0], 2'h0},
				32'h0000_0074);
		end
		v = $urandom;
		@(posedge ref_clk);
		{single_turn_position, multiturn_position, abs_encoder_present} <= {v[23:0], v[31:20], 1'b1};
		{abs_encoder_turn_capacity, abs_encoder_periods_per_rev} <= {v[15:0], ~v};
		rd(sdsf_pkg::REG_POSITION, {8'h0, v[23:0]});
		rd(sdsf_pkg::REG_MULTITURN, {{20{v[31]}}, v[31:20]});
		rd(sdsf_pkg::REG_ABS_TURNS, {16'h0, v[15:0]});
		rd(sdsf_pkg::REG_ABS_PERIODS, ~v);
		abs_encoder_present <= 1'b0;
		rd(sdsf_pkg::REG_ABS_PERIODS, 32'h0);
		rd(sdsf_pkg::REG_IDENT, 32'({sdsf_pkg::BASE_UNIT_ID, sdsf_pkg::LOGIC_REVISION}),
			32'h1FF);
		{extended_fault_sources, primary_fault_source} <= {16'h0008, 5'h05};
		tick(3);
		chk({31'h0, fault_pin_conducting}, 32'h0);
		{extended_fault_sources, primary_fault_source} <= 21'h0;
		tick(3);
		rd(sdsf_pkg::REG_EXT_FAULT, 32'h0000_0008);
		rd(sdsf_pkg::REG_FAULT_NUM, 32'h0000_0005);
		rd(sdsf_pkg::REG_DRIVE, 32'h0, 32'h1);
		wr(sdsf_pkg::REG_CONTROL, 32'h0000_0037);
		tick(3);
		rd(sdsf_pkg::REG_FAULT_NUM, 32'h0);
		chk({31'h0, fault_pin_conducting}, 32'h1);
		{enable_conducting, direction_conducting, fast_step_conducting} <= 3'b100;
		tick(4);
		chk({30'h0, power_stage_on, run_pin_conducting}, 32'h3);
		wr(sdsf_pkg::REG_CONTROL, 32'h0000_0032);
		tick(3);
		chk({30'h0, power_stage_on, run_pin_conducting}, 32'h0);
		wr(sdsf_pkg::REG_CONTROL, 32'h0000_0033);
		wr(sdsf_pkg::REG_POS_CMD, 32'h0);
		repeat (5) begin
			tick(1);
			fast_step_conducting <= 1'b1;
			tick(2);
			fast_step_conducting <= 1'b0;
			tick(2);
		end
		rd(sdsf_pkg::REG_POS_CMD, 32'h0000_0005);
		// negative gear reverses the count for the same direction level
		wr(sdsf_pkg::REG_GEAR, 32'h0000_FF00);
		tick(1);
		fast_step_conducting <= 1'b1;
		tick(2);
		fast_step_conducting <= 1'b0;
		tick(2);
		rd(sdsf_pkg::REG_GEAR, 32'h0000_FF00);
		rd(sdsf_pkg::REG_POS_CMD, 32'h0000_0004);
		wr(sdsf_pkg::REG_GEAR, 32'h0000_0100);
		wr(8'h30, 32'h0, 2'b10);
		wr(sdsf_pkg::REG_CONTROL, 32'h0000_0031);
		quad_count_up <= 1'b1;
		repeat (3) begin
			tick(1);
			quad_count_pulse <= 1'b1;
			tick(1);
			quad_count_pulse <= 1'b0;
		end
		rd(sdsf_pkg::REG_POS_CMD, 32'h0000_0007);
		{current_fraction, commutation_mhz} <= {10'h258, 16'h03E8};
		tick(3);
		chk({31'h0, half_switching_rate_flag}, 32'h1);
		current_fraction <= 10'h190;
		tick(3);
		chk({31'h0, half_switching_rate_flag}, 32'h1);
		current_fraction <= 10'h12C;
		tick(3);
		chk({31'h0, half_switching_rate_flag}, 32'h0);
		tick(2);
		complete_run();
	end
endmodule
